// >>> hw/can_accept_pkg.sv
// Constants, register map and types shared by the acceptance block.
// Assumes a 32-bit classic Wishbone bus and a 20 MHz system clock.
package can_accept_pkg;
   localparam int NUM_MB = 16;
   localparam int ID_W = 29;
   localparam int IDX_W = 4;
   localparam int ERR_W = 9;
   localparam int ADR_W = 12;
   localparam logic [IDX_W-1:0] LOCAL_MB = 4'hf;

   // Register byte offsets and mailbox page numbers
   localparam logic [ADR_W-1:0] OFS_CTRL = 12'h000;
   localparam logic [ADR_W-1:0] OFS_STATUS = 12'h004;
   localparam logic [ADR_W-1:0] OFS_ERRCNT = 12'h008;
   localparam logic [ADR_W-1:0] OFS_GMASK = 12'h00c;
   localparam logic [ADR_W-1:0] OFS_LMASK = 12'h010;
   localparam logic [ADR_W-1:0] OFS_DIR = 12'h014;
   localparam logic [ADR_W-1:0] OFS_RREPLY = 12'h018;
   localparam logic [ADR_W-1:0] OFS_IMASK = 12'h01c;
   localparam logic [ADR_W-1:0] OFS_RXPEND = 12'h020;
   localparam logic [ADR_W-1:0] OFS_RXIRQ = 12'h024;
   localparam logic [ADR_W-1:0] OFS_TXIRQ = 12'h028;
   localparam logic [ADR_W-1:0] OFS_TXACK = 12'h02c;
   localparam logic [ADR_W-1:0] OFS_TXREQ = 12'h030;
   localparam logic [ADR_W-1:0] OFS_CDR = 12'h034;
   localparam logic [5:0] MBID_PAGE = 6'h02;
   localparam logic [4:0] MBDATA_PAGE = 5'h02;

   // Field positions
   localparam int CTRL_CFG_REQ = 0;
   localparam int CTRL_TEST_ERR = 1;
   localparam int CTRL_GME = 2;
   localparam int CTRL_LME = 3;
   localparam int STAT_CFG_ACT = 0;
   localparam int STAT_BUS_ON = 1;
   localparam int STAT_RX_BUSY = 2;
   localparam int MBID_EXT = 29;
   localparam int ERR_RX_LSB = 16;
   localparam int CDR_ON = 8;

   // Reset values
   localparam logic RST_CFG_REQ = 1'b1;
   localparam logic RST_CFG_ACT = 1'b1;

   // Timing, in bit times and system clock periods
   localparam int HOLD_STD_BITS = 47;
   localparam int HOLD_EXT_BITS = 67;
   localparam int HOLD_CLK_PERIODS = 16;
   localparam int HOLD_CLK_CYCLES = HOLD_CLK_PERIODS * 1;
   localparam int IDLE_BITS = 11;

   typedef enum logic [1:0] {RX_IDLE, RX_CMP, RX_HOLD} rx_state_t;
endpackage : can_accept_pkg

// >>> hw/can_id_match.sv
// Identifier compare of one mailbox against the receive buffer.
// Purely combinational; the caller picks the mask for the mailbox.
`timescale 1ns/1ps
module can_id_match
   import can_accept_pkg::*;
(
   input wire logic [can_accept_pkg::ID_W-1:0] i_mb_id,
   input wire logic i_mb_ext,
   input wire logic [can_accept_pkg::ID_W-1:0] i_rx_id,
   input wire logic i_rx_ext,
   input wire logic [can_accept_pkg::ID_W-1:0] i_mask,
   input wire logic i_mask_en,
   output logic o_hit
);
   logic [ID_W-1:0] care;

   always_comb begin
      care = i_mask_en ? ~i_mask : {ID_W{1'b1}}; // RL7 RL18
      o_hit = (i_mb_ext == i_rx_ext) && (((i_mb_id ^ i_rx_id) & care) == '0);
   end
endmodule : can_id_match

// >>> hw/can_idle_detect.sv
// Synchronises the bus receive pin and waits for a run of recessive bits.
// Assumes i_bit_tick is a one-cycle pulse at the sample point of each bit.
`timescale 1ns/1ps
module can_idle_detect
   import can_accept_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_enable,
   input wire logic i_bit_tick,
   input wire logic i_can_rx,
   output logic o_done
);
   typedef struct packed {
      logic sync1;
      logic sync2;
      logic [3:0] cnt;
      logic done;
   } idle_state_t;

   idle_state_t s_reg;
   idle_state_t s_next;

   always_comb begin
      s_next = s_reg;
      s_next.sync1 = i_can_rx;
      s_next.sync2 = s_reg.sync1;
      if (!i_enable) begin
         s_next.cnt = '0;
         s_next.done = 1'b0;
      end else if (i_bit_tick && !s_reg.done) begin
         if (!s_reg.sync2) begin
            s_next.cnt = '0;
         end else if (s_reg.cnt == 4'(IDLE_BITS - 1)) begin
            s_next.done = 1'b1; // RL15
         end else begin
            s_next.cnt = s_reg.cnt + 4'h1;
         end
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign o_done = s_reg.done;

   a_idle_needs_run: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      $rose(s_reg.done) |-> $past(s_reg.cnt) == 4'(IDLE_BITS - 1)) // RL15
      else $error("bus joined without a full recessive run");
endmodule : can_idle_detect

// >>> hw/can_test_error_and_rx_accept.sv
// Mailbox acceptance, flags, test error counters and Wishbone registers.
// Assumes a bit engine on the same clock that hands in whole frames and
// sends whole frames, and a bit-rate tick from the bit timing logic.
// Contract
// RL1 - Error counter writes take effect only while test error mode is on.
// RL2 - One write loads both error counters with written bits 7 to 0.
// RL3 - Written counters never exceed 255; 256 is unreachable by software.
// RL4 - Software toggles test error mode only during configuration mode.
// RL5 - Per-mailbox transmit acknowledge flag for polling without interrupts.
// RL6 - Received frame is buffered first, then compared with mailbox ids.
// RL7 - Enabled global or local mask is applied in the id compare.
// RL8 - Compare stops at first receive match or remote-reply transmit match.
// RL9 - Remote frame hitting reply-enabled transmit mailbox triggers reply.
// RL10 - Software updates reply mailbox data under change data request.
// RL11 - After pending set, 47 or 67 bit times plus 16 clocks pass.
// RL12 - Per-mailbox receive pending flag for polling without interrupts.
// RL13 - Pending may set again with irq flag zero after split clears.
// RL14 - Software checks both pending and irq flag of a mailbox.
// RL15 - Reset into config mode; leaving it waits eleven recessive bits.
// RL16 - Masked reception sets irq flag; pulse only if none already set.
// RL17 - Writing one clears an irq flag; writing zero leaves it.
// RL18 - Mask bit one is don't care; other id bits must match.
`timescale 1ns/1ps
module can_test_error_and_rx_accept
   import can_accept_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [can_accept_pkg::ADR_W-1:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   input wire logic i_bit_tick,
   input wire logic i_can_rx,
   input wire logic i_rx_valid,
   input wire logic [can_accept_pkg::ID_W-1:0] i_rx_id,
   input wire logic i_rx_ext,
   input wire logic i_rx_rtr,
   input wire logic [63:0] i_rx_data,
   output logic o_rx_ready,
   output logic o_tx_valid,
   output logic [can_accept_pkg::IDX_W-1:0] o_tx_mailbox,
   output logic [can_accept_pkg::ID_W-1:0] o_tx_id,
   output logic o_tx_ext,
   output logic [63:0] o_tx_data,
   input wire logic i_tx_done,
   output logic o_bus_on,
   output logic o_rx_interrupt,
   output logic o_tx_interrupt,
   output logic o_irq
);
   import can_accept_pkg::*;

   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
      logic cfg_req;
      logic cfg_active;
      logic test_err;
      logic gme;
      logic lme;
      logic [ERR_W-1:0] tx_err;
      logic [ERR_W-1:0] rx_err;
      logic [ID_W-1:0] global_accept_mask;
      logic [ID_W-1:0] local_accept_mask;
      logic [NUM_MB-1:0] dir;
      logic [NUM_MB-1:0] rre;
      logic [NUM_MB-1:0] imask;
      logic [NUM_MB-1:0] rx_pend;
      logic [NUM_MB-1:0] rx_irq;
      logic [NUM_MB-1:0] tx_irq;
      logic [NUM_MB-1:0] tx_ack;
      logic [NUM_MB-1:0] tx_req;
      logic [NUM_MB-1:0] reply;
      logic [IDX_W-1:0] cdr_mb;
      logic cdr_on;
      logic [NUM_MB-1:0][ID_W:0] mb_id;
      logic [NUM_MB-1:0][63:0] mb_data;
      logic [ID_W-1:0] buf_id;
      logic buf_ext;
      logic buf_rtr;
      logic [63:0] buf_data;
      rx_state_t rx_st;
      logic [IDX_W-1:0] idx;
      logic [6:0] hold_bits;
      logic [4:0] hold_clk;
      logic tx_busy;
      logic [IDX_W-1:0] tx_sel;
      logic rx_int;
      logic tx_int;
   } state_t;

   state_t s_reg;
   state_t s_next;
   logic idle_done;
   logic bus_on;
   logic hit;
   logic wb_req;
   logic wr;
   logic [31:0] wmask;
   logic [31:0] wd;
   logic [ADR_W-1:0] a;
   logic [IDX_W-1:0] ai;
   logic [NUM_MB-1:0] clr;
   logic [6:0] hold_target;
   logic found;
   logic mb_ext;
   logic [ID_W-1:0] mb_idv;

   assign mb_ext = s_reg.mb_id[s_reg.idx][MBID_EXT];
   assign mb_idv = s_reg.mb_id[s_reg.idx][ID_W-1:0];

   can_idle_detect u_idle (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_enable(!s_reg.cfg_active),
      .i_bit_tick(i_bit_tick),
      .i_can_rx(i_can_rx),
      .o_done(idle_done)
   );

   // Mailbox 15 uses the local mask, all others the global one
   can_id_match u_match (
      .i_mb_id(mb_idv),
      .i_mb_ext(mb_ext),
      .i_rx_id(s_reg.buf_id),
      .i_rx_ext(s_reg.buf_ext),
      .i_mask(s_reg.idx == LOCAL_MB ? s_reg.local_accept_mask : s_reg.global_accept_mask),
      .i_mask_en(s_reg.idx == LOCAL_MB ? s_reg.lme : s_reg.gme),
      .o_hit(hit)
   );

   assign bus_on = !s_reg.cfg_active && idle_done;
   assign wb_req = i_wb_cyc && i_wb_stb;
   assign wr = wb_req && s_reg.ack && i_wb_we;
   assign a = i_wb_adr;
   assign ai = (a[11:7] == MBDATA_PAGE) ? a[6:3] : a[5:2];
   assign wmask = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}},
                   {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
   assign wd = i_wb_dat & wmask;
   assign clr = wr ? wd[NUM_MB-1:0] : '0;
   assign hold_target = s_reg.buf_ext ? 7'(HOLD_EXT_BITS) : 7'(HOLD_STD_BITS);

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] m,
                                         input logic [31:0] d);
      merge = (old & ~m) | (d & m);
   endfunction : merge

   always_comb begin
      s_next = s_reg;
      s_next.rx_int = 1'b0;
      s_next.tx_int = 1'b0;
      s_next.ack = wb_req && !s_reg.ack;
      found = 1'b0;
      // Read data latched on the same edge that raises ack, so it is stable under ack
      if (wb_req && !s_reg.ack) begin
         s_next.rdata = '0;
         case (a)
            OFS_CTRL: s_next.rdata = 32'({s_reg.lme, s_reg.gme,
                                          s_reg.test_err, s_reg.cfg_req});
            OFS_STATUS: s_next.rdata = 32'({s_reg.rx_st != RX_IDLE,
                                            bus_on, s_reg.cfg_active});
            OFS_ERRCNT: s_next.rdata = {7'h00, s_reg.rx_err,
                                        7'h00, s_reg.tx_err};
            OFS_GMASK: s_next.rdata = 32'(s_reg.global_accept_mask);
            OFS_LMASK: s_next.rdata = 32'(s_reg.local_accept_mask);
            OFS_DIR: s_next.rdata = 32'(s_reg.dir);
            OFS_RREPLY: s_next.rdata = 32'(s_reg.rre);
            OFS_IMASK: s_next.rdata = 32'(s_reg.imask);
            OFS_RXPEND: s_next.rdata = 32'(s_reg.rx_pend);
            OFS_RXIRQ: s_next.rdata = 32'(s_reg.rx_irq & s_reg.dir);
            OFS_TXIRQ: s_next.rdata = 32'(s_reg.tx_irq);
            OFS_TXACK: s_next.rdata = 32'(s_reg.tx_ack);
            OFS_TXREQ: s_next.rdata = 32'(s_reg.tx_req | s_reg.reply);
            OFS_CDR: s_next.rdata = 32'({s_reg.cdr_on, 4'h0, s_reg.cdr_mb});
            default: begin
               if (a[11:6] == MBID_PAGE) begin
                  s_next.rdata = 32'(s_reg.mb_id[ai]);
               end else if (a[11:7] == MBDATA_PAGE) begin
                  s_next.rdata = a[2] ? s_reg.mb_data[ai][63:32]
                                      : s_reg.mb_data[ai][31:0];
               end
            end
         endcase
      end
      // Software writes first, so hardware sets below win over clears
      if (wr) begin
         case (a)
            OFS_CTRL: begin
               if (i_wb_sel[0]) begin
                  s_next.cfg_req = i_wb_dat[CTRL_CFG_REQ];
                  s_next.gme = i_wb_dat[CTRL_GME];
                  s_next.lme = i_wb_dat[CTRL_LME];
                  if (s_reg.cfg_active) begin
                     s_next.test_err = i_wb_dat[CTRL_TEST_ERR]; // RL4
                  end
                  if (i_wb_dat[CTRL_CFG_REQ] && !s_reg.cfg_req) begin
                     s_next.tx_err = '0;
                     s_next.rx_err = '0;
                  end
               end
            end
            OFS_ERRCNT: begin
               if (s_reg.test_err && i_wb_sel[0]) begin // RL1
                  s_next.tx_err = {1'b0, i_wb_dat[7:0]}; // RL2 RL3
                  s_next.rx_err = {1'b0, i_wb_dat[7:0]}; // RL2 RL3
               end
            end
            OFS_GMASK: s_next.global_accept_mask = ID_W'(merge(32'(s_reg.global_accept_mask), wmask,
                                                 i_wb_dat));
            OFS_LMASK: s_next.local_accept_mask = ID_W'(merge(32'(s_reg.local_accept_mask), wmask,
                                                 i_wb_dat));
            OFS_DIR: s_next.dir = NUM_MB'(merge(32'(s_reg.dir), wmask,
                                                 i_wb_dat));
            OFS_RREPLY: s_next.rre = NUM_MB'(merge(32'(s_reg.rre), wmask,
                                                    i_wb_dat));
            OFS_IMASK: s_next.imask = NUM_MB'(merge(32'(s_reg.imask), wmask,
                                                     i_wb_dat));
            OFS_RXPEND: s_next.rx_pend = s_reg.rx_pend & ~clr;
            OFS_RXIRQ: begin
               s_next.rx_irq = s_reg.rx_irq & ~clr; // RL17
               if (clr != '0 && s_next.rx_irq != '0) begin
                  s_next.rx_int = 1'b1;
               end
            end
            OFS_TXIRQ: begin
               s_next.tx_irq = s_reg.tx_irq & ~clr; // RL17
               if (clr != '0 && s_next.tx_irq != '0) begin
                  s_next.tx_int = 1'b1;
               end
            end
            OFS_TXACK: s_next.tx_ack = s_reg.tx_ack & ~clr;
            OFS_TXREQ: s_next.tx_req = s_reg.tx_req | clr;
            OFS_CDR: begin
               if (i_wb_sel[0]) begin
                  s_next.cdr_mb = i_wb_dat[IDX_W-1:0];
               end
               if (i_wb_sel[1]) begin
                  s_next.cdr_on = i_wb_dat[CDR_ON];
               end
            end
            default: begin
               if (a[11:6] == MBID_PAGE) begin
                  s_next.mb_id[ai] = (ID_W+1)'(merge(32'(s_reg.mb_id[ai]),
                                                     wmask, i_wb_dat));
               end else if (a[11:7] == MBDATA_PAGE && a[2]) begin
                  s_next.mb_data[ai][63:32] =
                     merge(s_reg.mb_data[ai][63:32], wmask, i_wb_dat);
               end else if (a[11:7] == MBDATA_PAGE) begin
                  s_next.mb_data[ai][31:0] =
                     merge(s_reg.mb_data[ai][31:0], wmask, i_wb_dat);
               end
            end
         endcase
      end
      s_next.cfg_active = s_next.cfg_req; // RL15
      // Receive path: buffer, then walk the mailboxes one per cycle
      case (s_reg.rx_st)
         RX_IDLE: begin
            if (i_rx_valid && o_rx_ready) begin
               s_next.buf_id = i_rx_id; // RL6
               s_next.buf_ext = i_rx_ext;
               s_next.buf_rtr = i_rx_rtr;
               s_next.buf_data = i_rx_data;
               s_next.idx = '0;
               s_next.rx_st = RX_CMP;
            end
         end
         RX_CMP: begin
            if (hit && s_reg.dir[s_reg.idx]) begin // RL8
               s_next.rx_pend[s_reg.idx] = 1'b1; // RL12 RL13
               if (!s_reg.buf_rtr) begin
                  s_next.mb_data[s_reg.idx] = s_reg.buf_data;
               end
               if (s_reg.imask[s_reg.idx]) begin
                  s_next.rx_irq[s_reg.idx] = 1'b1; // RL16
                  s_next.rx_int = (s_reg.rx_irq == '0) || s_next.rx_int;
               end
               s_next.hold_bits = '0;
               s_next.hold_clk = '0;
               s_next.rx_st = RX_HOLD;
            end else if (hit && s_reg.buf_rtr && s_reg.rre[s_reg.idx]) begin
               s_next.reply[s_reg.idx] = 1'b1; // RL8 RL9
               s_next.rx_st = RX_IDLE;
            end else if (s_reg.idx == IDX_W'(NUM_MB - 1)) begin
               s_next.rx_st = RX_IDLE;
            end else begin
               s_next.idx = s_reg.idx + 4'h1;
            end
         end
         RX_HOLD: begin
            if (s_reg.hold_bits < hold_target) begin // RL11
               if (i_bit_tick) begin
                  s_next.hold_bits = s_reg.hold_bits + 7'h01;
               end
            end else if (s_reg.hold_clk < 5'(HOLD_CLK_CYCLES - 1)) begin
               s_next.hold_clk = s_reg.hold_clk + 5'h01;
            end else begin
               s_next.rx_st = RX_IDLE;
            end
         end
         default: s_next.rx_st = RX_IDLE;
      endcase
      // Transmit path: lowest pending transmit mailbox goes first
      if (s_reg.tx_busy) begin
         if (i_tx_done) begin
            s_next.tx_busy = 1'b0;
            s_next.tx_req[s_reg.tx_sel] = 1'b0;
            s_next.reply[s_reg.tx_sel] = 1'b0;
            s_next.tx_ack[s_reg.tx_sel] = 1'b1; // RL5
            if (s_reg.imask[s_reg.tx_sel]) begin
               s_next.tx_irq[s_reg.tx_sel] = 1'b1;
               s_next.tx_int = (s_reg.tx_irq == '0) || s_next.tx_int;
            end
         end
      end else if (bus_on) begin
         for (int i = 0; i < NUM_MB; i++) begin
            // Mailbox under data change is skipped, never sent half-updated
            if (!found && (s_reg.tx_req[i] || s_reg.reply[i]) &&
                !s_reg.dir[i] &&
                !(s_reg.cdr_on && s_reg.cdr_mb == IDX_W'(i))) begin // RL10
               found = 1'b1;
               s_next.tx_busy = 1'b1;
               s_next.tx_sel = IDX_W'(i);
            end
         end
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         s_reg <= '0;
         s_reg.cfg_req <= RST_CFG_REQ;
         s_reg.cfg_active <= RST_CFG_ACT; // RL15
      end else begin
         s_reg <= s_next;
      end
   end

   assign o_wb_ack = s_reg.ack;
   assign o_wb_dat = s_reg.rdata;
   assign o_rx_ready = (s_reg.rx_st == RX_IDLE) && bus_on;
   assign o_tx_valid = s_reg.tx_busy;
   assign o_tx_mailbox = s_reg.tx_sel;
   assign o_tx_id = s_reg.mb_id[s_reg.tx_sel][ID_W-1:0];
   assign o_tx_ext = s_reg.mb_id[s_reg.tx_sel][MBID_EXT];
   assign o_tx_data = s_reg.mb_data[s_reg.tx_sel];
   assign o_bus_on = bus_on;
   assign o_rx_interrupt = s_reg.rx_int;
   assign o_tx_interrupt = s_reg.tx_int;
   assign o_irq = |((s_reg.rx_irq | s_reg.tx_irq) & s_reg.imask);

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   a_err_write_gate: assert property ( // RL1
      wr && a == OFS_ERRCNT && !s_reg.test_err
      |=> $stable(s_reg.tx_err) && $stable(s_reg.rx_err))
      else $error("error counter changed outside test mode");
   a_err_both_load: assert property ( // RL2
      wr && a == OFS_ERRCNT && s_reg.test_err && i_wb_sel[0]
      |=> s_reg.tx_err == {1'b0, $past(i_wb_dat[7:0])} &&
          s_reg.rx_err == s_reg.tx_err)
      else $error("error counters not loaded together");
   a_err_max: assert property ( // RL3
      !s_reg.tx_err[ERR_W-1] && !s_reg.rx_err[ERR_W-1])
      else $error("error counter reached 256");
   a_tx_ack_set: assert property ( // RL5
      s_reg.tx_busy && i_tx_done |=> s_reg.tx_ack[$past(s_reg.tx_sel)]
      && !s_reg.tx_busy)
      else $error("transmit acknowledge not set");
   a_rx_buffer: assert property ( // RL6
      i_rx_valid && o_rx_ready |=> s_reg.rx_st == RX_CMP &&
      s_reg.buf_id == $past(i_rx_id) && s_reg.idx == '0)
      else $error("frame not buffered before compare");
   a_first_match: assert property ( // RL8
      s_reg.rx_st == RX_CMP && hit && s_reg.dir[s_reg.idx]
      |=> s_reg.rx_st == RX_HOLD && s_reg.rx_pend[$past(s_reg.idx)])
      else $error("compare went on past a match");
   a_exact_nomask: assert property ( // RL7
      s_reg.rx_st == RX_CMP && hit && s_reg.idx != LOCAL_MB && !s_reg.gme
      |-> mb_idv == s_reg.buf_id)
      else $error("unmasked compare accepted a different id");
   a_mask_care: assert property ( // RL18
      s_reg.rx_st == RX_CMP && s_reg.idx != LOCAL_MB && s_reg.gme &&
      mb_ext == s_reg.buf_ext &&
      ((mb_idv ^ s_reg.buf_id) & ~s_reg.global_accept_mask) == '0 |-> hit)
      else $error("masked id bit not treated as don't care");
   a_auto_reply: assert property ( // RL9
      s_reg.rx_st == RX_CMP && hit && !s_reg.dir[s_reg.idx] &&
      s_reg.buf_rtr && s_reg.rre[s_reg.idx]
      |=> s_reg.reply[$past(s_reg.idx)] && s_reg.rx_st == RX_IDLE)
      else $error("remote frame did not queue reply");
   a_hold_time: assert property ( // RL11
      s_reg.rx_st == RX_CMP && s_next.rx_st == RX_HOLD
      |=> (!o_rx_ready)[*8])
      else $error("next frame taken inside hold time");
   a_cfg_off_bus: assert property ( // RL15
      s_reg.cfg_active |-> !o_bus_on && !o_rx_ready &&
      (s_reg.tx_busy || !s_next.tx_busy) ##1 !o_bus_on)
      else $error("configuration mode active on the bus");
   a_rx_irq_pulse: assert property ( // RL16
      s_reg.rx_st == RX_CMP && hit && s_reg.dir[s_reg.idx] &&
      s_reg.imask[s_reg.idx] && s_reg.rx_irq == '0 |=> o_rx_interrupt)
      else $error("first receive flag gave no pulse");
   a_w1c_clear: assert property ( // RL17
      wr && a == OFS_TXIRQ && !(s_reg.tx_busy && i_tx_done)
      |=> s_reg.tx_irq == ($past(s_reg.tx_irq) & ~$past(clr)))
      else $error("write one did not clear flag");
   a_rx_w1c_clear: assert property ( // RL17
      wr && a == OFS_RXIRQ && s_reg.rx_st != RX_CMP
      |=> s_reg.rx_irq == ($past(s_reg.rx_irq) & ~$past(clr)))
      else $error("write one did not clear receive flag");

   c_rx_match: cover property (s_reg.rx_st == RX_CMP ##1
      s_reg.rx_st == RX_HOLD);
   c_auto_reply: cover property ($rose(|s_reg.reply));
   c_tx_done: cover property (s_reg.tx_busy && i_tx_done);
   c_test_write: cover property (wr && a == OFS_ERRCNT && s_reg.test_err);
endmodule : can_test_error_and_rx_accept

// >>> sim/can_node_model.sv
// Far bus node: bit ticks, idle recessive line, slow transmit completion.
// Assumes the block under test shares its clock.
`timescale 1ns/1ps
module can_node_model #(
   parameter int DONE_DLY = 30
) (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_tx_valid,
   output logic o_bit_tick,
   output logic o_can_rx,
   output logic o_tx_done
);
   logic [1:0] div;
   int wait_cnt;
   // Idle bus stays recessive, so power-up can complete
   assign o_can_rx = 1'h1;
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         div <= '0;
         o_bit_tick <= 1'h0;
         o_tx_done <= 1'h0;
         wait_cnt <= 0;
      end else begin
         div <= div + 2'h1;
         o_bit_tick <= (div == 2'h3);
         if (i_tx_valid && !o_tx_done) begin
            o_tx_done <= (wait_cnt == DONE_DLY);
            wait_cnt <= (wait_cnt == DONE_DLY) ? 0 : wait_cnt + 1;
         end else begin
            o_tx_done <= 1'h0;
         end
      end
   end
endmodule : can_node_model

// >>> sim/tb_can_test_error_and_rx_accept.sv
// Bench: Wishbone register tasks plus received-frame scenarios.
// Assumes the node model supplies ticks and ends transmits slowly.
`timescale 1ns/1ps
module tb_can_test_error_and_rx_accept;
   import can_accept_pkg::*;
   logic i_clk_sys = 1'h0, i_rst = 1'h1, cyc = 1'h0, we = 1'h0;
   logic rx_valid = 1'h0, rtr = 1'h0;
   logic [ADR_W-1:0] adr = '0;
   logic [31:0] wdat = '0, rdat, q;
   logic [ID_W-1:0] rx_id = '0, txid;
   logic [IDX_W-1:0] txmb;
   logic ack, ready, txv, tick, canrx, txdone, irq, rxi, txi;
   logic [63:0] txdat;
   int error_cnt = 0, compares = 0, cyc_cnt = 0, pulses = 0;
   can_test_error_and_rx_accept u_can_test_error_and_rx_accept (
      .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_wb_cyc(cyc), .i_wb_stb(cyc),
      .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(wdat),
      .o_wb_dat(rdat), .o_wb_ack(ack), .i_bit_tick(tick), .i_can_rx(canrx),
      .i_rx_valid(rx_valid), .i_rx_id(rx_id), .i_rx_ext(1'h0),
      .i_rx_rtr(rtr), .i_rx_data(64'h0), .o_rx_ready(ready),
      .o_tx_valid(txv), .o_tx_mailbox(txmb), .o_tx_id(txid), .o_tx_ext(),
      .o_tx_data(txdat), .i_tx_done(txdone), .o_bus_on(),
      .o_rx_interrupt(rxi), .o_tx_interrupt(txi), .o_irq(irq));
   can_node_model u_can_node_model (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
      .i_tx_valid(txv), .o_bit_tick(tick), .o_can_rx(canrx),
      .o_tx_done(txdone));
   initial forever #25 i_clk_sys = ~i_clk_sys;
   task automatic tally_and_finish();
      if (error_cnt == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : tally_and_finish
   always @(posedge i_clk_sys) begin
      cyc_cnt++;
      // Tx pulses weigh 16 so either kind going astray shows
      if (!i_rst && rxi !== 1'h0) pulses++;
      if (!i_rst && txi !== 1'h0) pulses += 16;
      if (cyc_cnt == 4000) begin
         error_cnt++;
         tally_and_finish();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [ADR_W-1:0] a,
                     input logic [31:0] d);
      cyc <= 1'h1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge i_clk_sys); while (ack !== 1'h1);
      q = rdat;
      cyc <= 1'h0;
      @(posedge i_clk_sys);
   endtask : wb
   // Frame is held until the block is ready, as the bus engine would
   task automatic frame(input logic [ID_W-1:0] id, input logic r);
      rx_id <= id;
      rtr <= r;
      rx_valid <= 1'h1;
      do @(posedge i_clk_sys); while (ready !== 1'h1);
      rx_valid <= 1'h0;
      repeat (20) @(posedge i_clk_sys);
   endtask : frame
   initial begin
      repeat (6) @(posedge i_clk_sys);
      i_rst <= 1'h0;
      @(posedge i_clk_sys);
      wb(1'h0, OFS_STATUS, 32'h0);
      chk(q, 32'h1);
      wb(1'h1, OFS_ERRCNT, 32'hab);
      wb(1'h0, OFS_ERRCNT, 32'h0);
      chk(q, 32'h0);
      wb(1'h1, OFS_CTRL, 32'h3);
      wb(1'h1, OFS_ERRCNT, 32'h1ff);
      wb(1'h0, OFS_ERRCNT, 32'h0);
      chk(q, 32'h00ff00ff);
      wb(1'h1, OFS_GMASK, 32'h23);
      wb(1'h1, OFS_DIR, 32'ha);
      wb(1'h1, OFS_RREPLY, 32'h10);
      wb(1'h1, OFS_IMASK, 32'h2);
      wb(1'h1, 12'h084, 32'h100);
      wb(1'h1, 12'h08c, 32'h123);
      wb(1'h1, 12'h090, 32'h55);
      wb(1'h1, OFS_CDR, 32'h104);
      wb(1'h1, 12'h120, 32'h5a5a);
      wb(1'h1, OFS_CDR, 32'h4);
      wb(1'h1, OFS_CTRL, 32'h6);
      q = '0;
      for (int i = 0; i < 50 && q[1] !== 1'h1; i++) wb(1'h0, OFS_STATUS, 0);
      chk(q, 32'h2);
      wb(1'h0, 12'hffc, 32'h0);
      chk(q, 32'h0);
      // Mask makes mailbox 1 hit ahead of exact-match mailbox 3
      frame(29'h123, 1'h0);
      wb(1'h0, OFS_RXPEND, 32'h0);
      chk(q, 32'h2);
      wb(1'h0, OFS_RXIRQ, 32'h0);
      chk(q, 32'h2);
      chk({31'h0, irq}, 32'h1);
      wb(1'h1, OFS_RXIRQ, 32'h2);
      wb(1'h0, OFS_RXIRQ, 32'h0);
      chk(q, 32'h0);
      chk({31'h0, irq}, 32'h0);
      // Masks off: the remote frame must hit by exact compare
      wb(1'h1, OFS_CTRL, 32'h0);
      frame(29'h55, 1'h1);
      chk({31'h0, txv}, 32'h1);
      chk({28'h0, txmb}, 32'h4);
      chk({3'h0, txid}, 32'h55);
      chk(txdat[31:0], 32'h5a5a);
      repeat (20) @(posedge i_clk_sys);
      wb(1'h0, OFS_TXACK, 32'h0);
      chk(q, 32'h10);
      wb(1'h0, OFS_TXIRQ, 32'h0);
      chk(q, 32'h0);
      wb(1'h1, OFS_TXIRQ, 32'h10);
      wb(1'h0, OFS_TXIRQ, 32'h0);
      chk(q, 32'h0);
      chk(pulses, 32'h1);
      tally_and_finish();
   end
endmodule : tb_can_test_error_and_rx_accept
